/* File: hw/emp_clkgen.sv */
// bus clock output generator
`timescale 1ns/1ps
module emp_clkgen (
    input  wire logic sys_clk,
    input  wire logic rst_sync_n,
    input  wire logic ext_clk_s,
    input  wire logic pll_en,
    input  wire logic mult_one,
    input  wire logic div_one,
    output logic      clk_out,
    output logic      clk_rise
);

    logic clk_ff;
    logic clk_d_ff;
    logic ext_d_ff;
    logic ext_rise;
    logic nxt_clk;

    assign ext_rise = ext_clk_s & ~ext_d_ff;

    // ==========================================================
    // next clock level
    always_comb begin
        nxt_clk = clk_ff;
        if (!pll_en) begin
            if (ext_rise) begin
                nxt_clk = ~clk_ff;
            end
        end else if (mult_one && div_one && ext_rise) begin
            nxt_clk = 1'b1;
        end else begin
            nxt_clk = ~clk_ff;
        end
    end

    // clock and edge history
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            clk_ff   <= 1'b0;
            clk_d_ff <= 1'b0;
            ext_d_ff <= 1'b1;    // no false rise straight out of reset
        end else begin
            clk_ff   <= nxt_clk;
            clk_d_ff <= clk_ff;
            ext_d_ff <= ext_clk_s;
        end
    end

    assign clk_out  = clk_ff;
    assign clk_rise = clk_ff & ~clk_d_ff;

endmodule

/* File: hw/emp_port.sv */
// external memory expansion port pin logic
`timescale 1ns/1ps
`include "emp_regs.svh"
module emp_port (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   ext_clock_in,
    input  wire logic                   pll_init_pin,
    input  wire logic                   pll_mult_one,
    input  wire logic                   pll_div_one,
    input  wire logic                   async_arb_enable,
    input  wire logic                   lp_req,
    input  wire logic                   bus_grant_n,
    input  wire logic                   acc_req,
    input  wire logic                   acc_write,
    input  wire logic [`EMP_ADDR_W-1:0] acc_addr,
    input  wire logic [`EMP_DATA_W-1:0] acc_wdata,
    input  wire logic [`EMP_ATTR_W-1:0] acc_attr,
    output logic                        acc_ack,
    output logic      [`EMP_DATA_W-1:0] acc_rdata,
    output logic                        bus_master,
    output logic                        bus_clock_out,
    output logic                        bus_clock_out_usable,
    output logic                        pll_enable_bit,
    output logic      [`EMP_ADDR_W-1:0] addr_o,
    output logic                        addr_oe,
    input  wire logic [`EMP_DATA_W-1:0] data_i,
    output logic      [`EMP_DATA_W-1:0] data_o,
    output logic                        data_oe,
    output logic                        keeper_en,
    output logic      [`EMP_ATTR_W-1:0] addr_attr_o,
    output logic                        addr_attr_oe,
    output logic                        rd_n_o,
    output logic                        rd_n_oe,
    output logic                        wr_n_o,
    output logic                        wr_n_oe,
    output logic                        bus_busy_n_o,
    output logic                        bus_busy_n_oe
);

    // ==========================================================
    // declarations
    logic                   rst_meta_ff;
    logic                   rst_sync_ff;
    logic                   ext_clk_s;
    logic                   pll_init_s;
    logic                   grant_n_s;
    logic [`EMP_DATA_W-1:0] data_s;
    logic                   clk_rise;
    logic                   pll_en_ff;
    logic                   async_arb_ff;
    logic                   grant_sample;
    logic                   grant_seen;
    logic                   grant_lost;
    emp_pkg::emp_state_t    state_ff;
    emp_pkg::emp_state_t    nxt_state;
    logic [3:0]             cnt_ff;
    logic [`EMP_ADDR_W-1:0] addr_ff;
    logic [`EMP_DATA_W-1:0] wdata_ff;
    logic [`EMP_ATTR_W-1:0] attr_ff;
    logic                   write_ff;
    logic [`EMP_DATA_W-1:0] rdata_ff;
    logic                   ack_ff;
    logic                   last_out_ff;
    logic                   master;
    logic                   in_access;
    logic                   acc_start;
    logic                   acc_end;

    // ==========================================================
    // reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ==========================================================
    // pin input synchronisers
    emp_sync #(
        .W (3)
    ) u_sync_ctl (
        .sys_clk (sys_clk),
        .din     ({ext_clock_in, pll_init_pin, bus_grant_n}),
        .dout    ({ext_clk_s, pll_init_s, grant_n_s})
    );

    emp_sync #(
        .W (`EMP_DATA_W)
    ) u_sync_data (
        .sys_clk (sys_clk),
        .din     (data_i),
        .dout    (data_s)
    );

    // ==========================================================
    // pll enable strap, captured while reset is held
    always_ff @(posedge sys_clk) begin
        if (!rst_sync_ff) begin
            pll_en_ff <= pll_init_s;
        end
    end

    assign pll_enable_bit = pll_en_ff;

    // ==========================================================
    // bus clock output
    emp_clkgen u_clkgen (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_ff),
        .ext_clk_s  (ext_clk_s),
        .pll_en     (pll_en_ff),
        .mult_one   (pll_mult_one),
        .div_one    (pll_div_one),
        .clk_out    (bus_clock_out),
        .clk_rise   (clk_rise)
    );

    // clock output is only usable at or below the limit
    assign bus_clock_out_usable = (`EMP_CORE_MHZ <= `EMP_BUS_CLOCK_OUT_MAX_MHZ);

    // ==========================================================
    // arbitration mode register
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            async_arb_ff <= 1'b0;
        end else begin
            async_arb_ff <= async_arb_enable;
        end
    end

    // grant sampled at clock output rising edges unless async arbitration is on
    assign grant_sample = async_arb_ff | clk_rise;
    assign grant_seen   = grant_sample & ~grant_n_s;
    assign grant_lost   = grant_sample & grant_n_s;

    // ==========================================================
    // ownership state machine
    assign acc_start = (state_ff == emp_pkg::ST_OWNED) && !lp_req && !grant_lost && acc_req;
    assign acc_end   = (state_ff == emp_pkg::ST_ACCESS) && !lp_req
                       && (cnt_ff == `EMP_ACC_LAST);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            emp_pkg::ST_RELEASED: begin
                if (lp_req) begin
                    nxt_state = emp_pkg::ST_LOWPOWER;
                end else if (grant_seen) begin
                    nxt_state = emp_pkg::ST_OWNED;
                end
            end
            emp_pkg::ST_OWNED: begin
                if (lp_req) begin
                    nxt_state = emp_pkg::ST_LOWPOWER;
                end else if (grant_lost) begin
                    nxt_state = emp_pkg::ST_RELEASED;
                end else if (acc_req) begin
                    nxt_state = emp_pkg::ST_ACCESS;
                end
            end
            emp_pkg::ST_ACCESS: begin
                if (lp_req) begin
                    nxt_state = emp_pkg::ST_LOWPOWER;
                end else if (acc_end) begin
                    nxt_state = emp_pkg::ST_OWNED;
                end
            end
            emp_pkg::ST_LOWPOWER: begin
                if (!lp_req) begin
                    nxt_state = emp_pkg::ST_RELEASED;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= emp_pkg::ST_RELEASED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // access cycle counter
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cnt_ff <= 4'h0;
        end else if (acc_start) begin
            cnt_ff <= 4'h0;
        end else if (state_ff == emp_pkg::ST_ACCESS) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // ==========================================================
    // address, write data and attribute hold registers
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            addr_ff  <= '0;
            wdata_ff <= '0;
            attr_ff  <= `EMP_ATTR_IDLE;
            write_ff <= 1'b0;
        end else if (acc_start) begin
            addr_ff  <= acc_addr;
            attr_ff  <= acc_attr;
            write_ff <= acc_write;
            if (acc_write) begin
                wdata_ff <= acc_wdata;
            end
        end else if (acc_end) begin
            attr_ff <= `EMP_ATTR_IDLE;
        end
    end

    // read capture and completion pulse
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rdata_ff <= '0;
            ack_ff   <= 1'b0;
        end else begin
            ack_ff <= acc_end;
            if (acc_end && !write_ff) begin
                rdata_ff <= data_s;
            end
        end
    end

    assign acc_ack   = ack_ff;
    assign acc_rdata = rdata_ff;

    // ==========================================================
    // keeper tracking: last data state was output or input
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            last_out_ff <= 1'b0;
        end else if (data_oe) begin
            last_out_ff <= 1'b1;
        end else if (in_access && !write_ff) begin
            last_out_ff <= 1'b0;
        end
    end

    assign keeper_en = last_out_ff & ~data_oe;

    // ==========================================================
    // pin drivers
    assign master     = (state_ff == emp_pkg::ST_OWNED) || (state_ff == emp_pkg::ST_ACCESS);
    assign in_access  = (state_ff == emp_pkg::ST_ACCESS);
    assign bus_master = master;

    assign addr_o  = addr_ff;
    assign addr_oe = master;
    assign data_o  = wdata_ff;
    assign data_oe = in_access & write_ff;

    assign addr_attr_o  = attr_ff;
    assign addr_attr_oe = master;
    assign rd_n_o       = ~(in_access & ~write_ff);
    assign rd_n_oe      = master;
    assign wr_n_o       = ~(in_access & write_ff);
    assign wr_n_oe      = master;
    assign bus_busy_n_o  = ~master;
    assign bus_busy_n_oe = master;

endmodule

/* File: hw/emp_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module emp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ==========================================================
    // synchroniser chain, first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        meta_ff <= din;
        sync_ff <= meta_ff;
    end

    assign dout = sync_ff;

endmodule

/* File: include/emp_pkg.sv */
// types shared by the external memory port pin logic
package emp_pkg;

    // ======================================================
    // bus ownership state
    typedef enum logic [1:0] {
        ST_RELEASED,
        ST_OWNED,
        ST_ACCESS,
        ST_LOWPOWER
    } emp_state_t;

endpackage

/* File: include/emp_regs.svh */
// constants for the external memory port pin logic
`ifndef EMP_REGS_SVH
`define EMP_REGS_SVH

// ==========================================================
// bus widths
`define EMP_ADDR_W        18
`define EMP_DATA_W        24
`define EMP_ATTR_W        4

// ==========================================================
// access timing and clock limits
`define EMP_ACC_CYCLES    4'h4
`define EMP_ACC_LAST      (`EMP_ACC_CYCLES - 4'h1)
`define EMP_CORE_MHZ      16'h00FA
`define EMP_BUS_CLOCK_OUT_MAX_MHZ 16'h0064
`define EMP_ATTR_IDLE     4'h0

`endif

/* File: verification/emp_mem_model.sv */
// external memory model on the far side of the port
`timescale 1ns/1ps
`include "emp_regs.svh"
module emp_mem_model (
    input wire logic                   sys_clk,
    input wire logic [`EMP_ADDR_W-1:0] addr_o,
    input wire logic                   rd_n_o,
    input wire logic                   rd_n_oe,
    input wire logic                   wr_n_o,
    input wire logic                   wr_n_oe,
    input wire logic [`EMP_DATA_W-1:0] data_o,
    input wire logic                   data_oe,
    input wire logic                   keeper_en,
    output logic     [`EMP_DATA_W-1:0] data_i
);
    logic [`EMP_DATA_W-1:0] mem [16];
    logic [`EMP_DATA_W-1:0] last_ff = 24'h000000;
    // preload each word with a pattern of its index
    initial for (int i = 0; i < 16; i++) mem[i] = 24'h5A0000 | 24'(i);
    // resolve the shared data wire; nobody driving shows a moving value
    always_comb begin
        if (data_oe) data_i = data_o;
        else if (rd_n_oe && !rd_n_o) data_i = mem[addr_o[3:0]];
        else if (keeper_en) data_i = data_o;
        else data_i = ~last_ff;
    end
    // store writes and remember the wire level
    always @(posedge sys_clk) begin
        last_ff <= data_i;
        if (wr_n_oe && !wr_n_o && data_oe) mem[addr_o[3:0]] <= data_o;
    end
endmodule

/* File: verification/emp_port_properties.sv */
// concurrent checks on the memory port pins
`timescale 1ns/1ps
`include "emp_regs.svh"
module emp_chk (
    input wire logic                   sys_clk,
    input wire logic                   rst_n,
    input wire logic                   lp_req,
    input wire logic                   bus_grant_n,
    input wire logic                   async_arb_enable,
    input wire logic                   acc_req,
    input wire logic                   acc_write,
    input wire logic                   acc_ack,
    input wire logic                   bus_master,
    input wire logic [`EMP_ADDR_W-1:0] addr_o,
    input wire logic                   addr_oe,
    input wire logic                   data_oe,
    input wire logic                   keeper_en,
    input wire logic                   addr_attr_oe,
    input wire logic                   rd_n_o,
    input wire logic                   wr_n_o,
    input wire logic                   bus_busy_n_oe,
    input wire logic                   ext_clock_in,
    input wire logic                   pll_mult_one,
    input wire logic                   pll_div_one,
    input wire logic                   pll_enable_bit,
    input wire logic                   bus_clock_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ======================================================
    // access steps
    sequence s_take;
        bus_master && rd_n_o && wr_n_o && acc_req && !lp_req && !bus_grant_n
            && !$past(bus_grant_n, 1) && !$past(bus_grant_n, 2);
    endsequence
    sequence s_done;
        acc_ack && rd_n_o && wr_n_o && !data_oe;
    endsequence
    // ======================================================
    // ownership, release, access and clock properties
    property p_addr_oe; addr_oe == bus_master; endproperty
    property p_data_oe; data_oe |-> bus_master; endproperty
    property p_lp_rel;
        lp_req |=> !(bus_master || addr_oe || data_oe || addr_attr_oe || bus_busy_n_oe);
    endproperty
    property p_lp_exit; $fell(lp_req) |=> !addr_oe && !data_oe; endproperty
    property p_addr_hold; $changed(addr_o) |-> !rd_n_o || !wr_n_o; endproperty
    property p_keep; $fell(data_oe) |-> keeper_en; endproperty
    property p_async;
        (async_arb_enable && !lp_req && !bus_grant_n)[*5] |-> bus_master;
    endproperty
    property p_wr; s_take ##0 acc_write |=> (!wr_n_o && data_oe)[*4] ##1 s_done; endproperty
    property p_rd; s_take ##0 !acc_write |=> (!rd_n_o && !data_oe)[*4] ##1 s_done; endproperty
    property p_clk_align;
        pll_enable_bit && pll_mult_one && pll_div_one && $rose(ext_clock_in) |-> ##3 bus_clock_out;
    endproperty
    a_addr_oe: assert property (p_addr_oe) else $error("address enable not tied to mastership");
    a_data_oe: assert property (p_data_oe) else $error("data driven without mastership");
    a_lp_rel: assert property (p_lp_rel) else $error("pins not released in low power");
    a_lp_exit: assert property (p_lp_exit) else $error("pins driven right after low power");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved without access");
    a_keep: assert property (p_keep) else $error("keeper off after data drive");
    a_async: assert property (p_async) else $error("async grant not taken");
    a_wr: assert property (p_wr) else $error("write cycle shape wrong");
    a_rd: assert property (p_rd) else $error("read cycle shape wrong");
    a_clk_align: assert property (p_clk_align) else $error("clock out not on ext edge");
endmodule

bind emp_port emp_chk i_emp_chk (.sys_clk, .rst_n, .lp_req, .bus_grant_n, .async_arb_enable,
    .acc_req, .acc_write, .acc_ack, .bus_master, .addr_o, .addr_oe, .data_oe, .keeper_en,
    .addr_attr_oe, .rd_n_o, .wr_n_o, .bus_busy_n_oe, .ext_clock_in, .pll_mult_one,
    .pll_div_one, .pll_enable_bit, .bus_clock_out);

/* File: verification/ext_memory_port_pins_tb_top.sv */
// self-checking bench for the memory port pins
`timescale 1ns/1ps
`include "emp_regs.svh"
module ext_memory_port_pins_tb_top;
    logic sys_clk = 0, rst_n = 0, ext_clock_in = 0, pll_init_pin = 0, pll_mult_one = 1;
    logic pll_div_one = 1, async_arb_enable = 0, lp_req = 0, bus_grant_n = 1;
    logic acc_req = 0, acc_write = 0, acc_ack, bus_master, bus_clock_out, bus_clock_out_usable;
    logic pll_enable_bit, addr_oe, data_oe, keeper_en, addr_attr_oe, rd_n_o, rd_n_oe;
    logic wr_n_o, wr_n_oe, bus_busy_n_o, bus_busy_n_oe, prev;
    logic [`EMP_ADDR_W-1:0] acc_addr = 18'h00000, addr_o, a;
    logic [`EMP_DATA_W-1:0] acc_wdata = 24'h000000, acc_rdata, data_i, data_o, d;
    logic [`EMP_DATA_W-1:0] shadow [16];
    logic [`EMP_ATTR_W-1:0] acc_attr = 4'h0, addr_attr_o;
    int bad_count = 0, n_checks = 0, n;
    // ======================================================
    // clocks, design and far side
    initial forever #2 sys_clk = ~sys_clk;
    initial forever #16 ext_clock_in = ~ext_clock_in;
    emp_port i_emp_port (.sys_clk, .rst_n, .ext_clock_in, .pll_init_pin, .pll_mult_one,
        .pll_div_one, .async_arb_enable, .lp_req, .bus_grant_n, .acc_req, .acc_write,
        .acc_addr, .acc_wdata, .acc_attr, .acc_ack, .acc_rdata, .bus_master, .bus_clock_out,
        .bus_clock_out_usable, .pll_enable_bit, .addr_o, .addr_oe, .data_i, .data_o, .data_oe,
        .keeper_en, .addr_attr_o, .addr_attr_oe, .rd_n_o, .rd_n_oe, .wr_n_o, .wr_n_oe,
        .bus_busy_n_o, .bus_busy_n_oe);
    emp_mem_model i_emp_mem_model (.sys_clk, .addr_o, .rd_n_o, .rd_n_oe, .wr_n_o, .wr_n_oe,
        .data_o, .data_oe, .keeper_en, .data_i);
    // ======================================================
    // helpers
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task limit(input logic ok);
        if (!ok) begin
            bad_count++;
            $display("[ERR] %0t wait ran out", $time);
            end_of_test();
        end
    endtask
    task do_reset(input logic pll);
        rst_n = 0;
        pll_init_pin = pll;
        tick(6);
        chk({addr_oe, data_oe, bus_master, bus_clock_out}, 0);
        rst_n = 1;
        tick(4);
        chk(pll_enable_bit, pll);
        chk(bus_clock_out_usable, 1'b0);
    endtask
    // count rising edges of the bus clock over 160 core cycles
    task count_rises;
        n = 0;
        prev = bus_clock_out;
        repeat (160) begin
            tick(1);
            if (bus_clock_out && !prev) n++;
            prev = bus_clock_out;
        end
    endtask
    task grab;
        int k;
        bus_grant_n = 0;
        for (k = 0; k < 100 && bus_master !== 1'b1; k++) tick(1);
        limit(k < 100);
        chk({addr_oe, bus_busy_n_o}, 2'b10);
    endtask
    task access(input logic w);
        int k;
        acc_write = w;
        acc_addr = a;
        acc_wdata = d;
        acc_attr = 4'h1;
        acc_req = 1;
        for (k = 0; k < 20 && acc_ack !== 1'b1; k++) tick(1);
        limit(k < 20);
        acc_req = 0;
        if (w) chk(data_i, d);
        else chk(acc_rdata, shadow[a[3:0]]);
        if (w) shadow[a[3:0]] = d;
        tick(1);
    endtask
    // ======================================================
    // main sequence
    initial begin
        void'($urandom(12855));
        for (int i = 0; i < 16; i++) shadow[i] = 24'h5A0000 | 24'(i);
        do_reset(0);
        count_rises();
        chk(n >= 9 && n <= 11, 1);
        $display("clock test done");
        grab();
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 18'h3FFFF : 18'($urandom);
            d = (i == 1) ? 24'hFFFFFF : 24'($urandom);
            access(i < 2 ? 1'b1 : 1'($urandom));
        end
        tick(5);
        chk(addr_o, a);
        $display("access test done");
        lp_req = 1;
        bus_grant_n = 1;
        tick(2);
        chk({addr_oe, data_oe, addr_attr_oe, rd_n_oe, wr_n_oe, bus_busy_n_oe}, 0);
        lp_req = 0;
        tick(6);
        chk({addr_oe, data_oe, bus_master}, 0);
        async_arb_enable = 1;
        grab();
        for (int i = 0; i < 6; i++) begin
            a = 18'($urandom);
            d = 24'($urandom);
            access(1'(i));
        end
        $display("low power test done");
        do_reset(1);
        count_rises();
        chk(n >= 76 && n <= 80, 1);
        $display("second reset done");
        end_of_test();
    end
endmodule
